/* File: src/acltia_top.sv */
// Purpose: Per port indirect access engine for the rule table.
// Assumes: Host uses a byte wide register port synchronous to i_clk.
// Notes: Table transfers step one byte per cycle, so completion takes fourteen cycles.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R1 - Force miss bit: single entry, match is miss
// R2 - Bit clear: multiple entries, rule set hit
// R3 - Select bits 7:5 value 010, port 1-5
// R4 - Offset register maps data register onto location
// R5 - Select bit 4 set reads, clear writes
// R6 - Fourteen bit byte enable at 0x10/0x11
// R7 - 0x3F and 0xFF enable all fourteen bytes
// R8 - Mask bit 13-k enables entry byte k
// R9 - Control at 0x12, bit4 clear reads entry
// R10 - Host polls bit 5 before fetching data
// R11 - Fetched bytes appear at offsets 0x00-0x0D
// R12 - Single or burst access across offsets
// R13 - Host polls bit 6 before writing
// R14 - Entry byte writes land in holding buffer
// R15 - Write request copies enabled bytes to entry
// R16 - Layer-2 layout when mode field is 01
// R17 - Completion flags reset to one
// R18 - Request clears flag, finish sets it
module acltia_top
  import acltia_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic [PORTS-1:0] o_single_entry_filter,
  output logic [PORTS-1:0] o_match_is_miss,
  output logic [PORTS-1:0] o_layer2_layout
);
  // The table has no reset, so an entry read before it was ever written returns unknown bytes.
  logic [7:0] table_mem [PORTS][ENTRIES][ENTRY_BYTES];
  logic [7:0] hold_q [PORTS][ENTRY_BYTES];
  logic [7:0] hold_d [PORTS][ENTRY_BYTES];
  logic [13:0] mask_q [PORTS];
  logic [13:0] mask_d [PORTS];
  logic [3:0] index_q [PORTS];
  logic [3:0] index_d [PORTS];
  logic [PORTS-1:0] force_q, force_d;
  logic [PORTS-1:0] rdone_q, rdone_d, wdone_q, wdone_d;
  logic [PORTS-1:0] rtype_q, rtype_d;
  logic [7:0] sel_q, sel_d, ofs_q, ofs_d, rdata_q, rdata_d;
  acltia_state_type state_q, state_d;
  logic [2:0] xport_q, xport_d;
  logic [3:0] step_q, step_d;
  logic lane_en;
  logic [PORTS-1:0] force_o_q, miss_o_q, l2_q;

  function automatic logic [2:0] port_of(input logic [7:0] sel);
    logic [3:0] p;
    p = sel[3:0];
    if (p >= 4'h1 && p <= 4'h5) begin
      port_of = 3'(p - 4'h1);
    end else begin
      port_of = 3'h0;
    end
  endfunction

  function automatic logic sel_ok(input logic [7:0] sel);
    sel_ok = (sel[7:SEL_TABLE_LSB] == TABLE_RULE) && (sel[3:0] >= 4'h1) &&
             (sel[3:0] <= 4'h5); // see R3
  endfunction

  logic [2:0] cur_port;
  logic data_wr, data_rd, sel_valid;
  assign cur_port = port_of(sel_q);
  assign sel_valid = sel_ok(sel_q);
  assign data_wr = i_reg_wr && i_reg_addr == ADDR_DATA && sel_valid && !sel_q[SEL_DIR_BIT]; // see R5
  assign data_rd = i_reg_rd && i_reg_addr == ADDR_DATA && sel_valid && sel_q[SEL_DIR_BIT]; // see R5

  acltia_byte_lane u_lane (
    .i_mask(mask_q[xport_q]),
    .i_index(step_q),
    .o_enable(lane_en)
  );

  always_comb begin
    sel_d = sel_q;
    ofs_d = ofs_q;
    hold_d = hold_q;
    mask_d = mask_q;
    index_d = index_q;
    force_d = force_q;
    rdone_d = rdone_q;
    wdone_d = wdone_q;
    rtype_d = rtype_q;
    state_d = state_q;
    xport_d = xport_q;
    step_d = step_q;
    rdata_d = rdata_q;
    if (i_reg_wr && i_reg_addr == ADDR_SELECT) begin
      sel_d = i_reg_wdata;
    end
    if (i_reg_wr && i_reg_addr == ADDR_OFFSET) begin
      ofs_d = i_reg_wdata; // see R4
    end
    // An offset write in the same cycle as a data access loses to the step.
    if (data_wr || data_rd) begin
      ofs_d = 8'(ofs_q + 8'h01); // see R12
    end
    if (state_q == ACLTIA_READ) begin
      if (lane_en) begin
        hold_d[xport_q][step_q] = table_mem[xport_q][index_q[xport_q]][step_q];
      end
      if (step_q == 4'(XFER_CYCLES - 1)) begin
        rdone_d[xport_q] = 1'b1; // see R18
        state_d = ACLTIA_IDLE;
      end
      step_d = 4'(step_q + 4'h1);
    end else if (state_q == ACLTIA_WRITE) begin
      if (step_q == 4'(XFER_CYCLES - 1)) begin
        wdone_d[xport_q] = 1'b1; // see R18
        state_d = ACLTIA_IDLE;
      end
      step_d = 4'(step_q + 4'h1);
    end
    // Host writes come last so they win over a fetch into the same holding byte.
    if (data_wr) begin
      if (ofs_q <= OFS_ENTRY_LAST) begin
        hold_d[cur_port][ofs_q[3:0]] = i_reg_wdata; // see R14
      end else if (ofs_q == OFS_MASK_HI) begin
        mask_d[cur_port][13:8] = i_reg_wdata[5:0]; // see R6, R7
      end else if (ofs_q == OFS_MASK_LO) begin
        mask_d[cur_port][7:0] = i_reg_wdata; // see R6, R7
      end else if (ofs_q == OFS_ACCESS && state_q == ACLTIA_IDLE) begin
        // A request while a transfer runs is dropped, so the host must poll the flags first.
        index_d[cur_port] = i_reg_wdata[3:0]; // see R9
        rtype_d[cur_port] = i_reg_wdata[CTL_REQ_BIT]; // see R9, R15
        xport_d = cur_port;
        step_d = 4'h0;
        if (i_reg_wdata[CTL_REQ_BIT]) begin
          wdone_d[cur_port] = 1'b0; // see R18, R15
          state_d = ACLTIA_WRITE;
        end else begin
          rdone_d[cur_port] = 1'b0; // see R18
          state_d = ACLTIA_READ;
        end
      end else if (ofs_q == OFS_FILTER) begin
        force_d[cur_port] = i_reg_wdata[0]; // see R1, R2
      end
    end
    if (data_rd) begin
      rdata_d = 8'h00;
      if (ofs_q <= OFS_ENTRY_LAST) begin
        rdata_d = hold_q[cur_port][ofs_q[3:0]]; // see R11
      end else if (ofs_q == OFS_MASK_HI) begin
        rdata_d = {2'h0, mask_q[cur_port][13:8]};
      end else if (ofs_q == OFS_MASK_LO) begin
        rdata_d = mask_q[cur_port][7:0];
      end else if (ofs_q == OFS_ACCESS) begin
        rdata_d = {1'b0, wdone_q[cur_port], rdone_q[cur_port], rtype_q[cur_port],
                   index_q[cur_port]}; // see R10, R13
      end else if (ofs_q == OFS_FILTER) begin
        rdata_d = {7'h00, force_q[cur_port]};
      end
    end else if (i_reg_rd) begin
      rdata_d = 8'h00;
      if (i_reg_addr == ADDR_SELECT) begin
        rdata_d = sel_q;
      end else if (i_reg_addr == ADDR_OFFSET) begin
        rdata_d = ofs_q;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (state_q == ACLTIA_WRITE && lane_en) begin
      table_mem[xport_q][index_q[xport_q]][step_q] <= hold_q[xport_q][step_q]; // see R15
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sel_q <= 8'h00;
      ofs_q <= 8'h00;
      for (int p = 0; p < PORTS; p++) begin
        mask_q[p] <= 14'h0000;
        index_q[p] <= 4'h0;
        for (int b = 0; b < ENTRY_BYTES; b++) begin
          hold_q[p][b] <= 8'h00;
        end
      end
      force_q <= {PORTS{FILTER_RESET[0]}};
      rdone_q <= {PORTS{1'b1}}; // see R17
      wdone_q <= {PORTS{1'b1}}; // see R17
      rtype_q <= {PORTS{1'b0}};
      state_q <= ACLTIA_IDLE;
      xport_q <= 3'h0;
      step_q <= 4'h0;
      rdata_q <= 8'h00;
    end else begin
      sel_q <= sel_d;
      ofs_q <= ofs_d;
      hold_q <= hold_d;
      mask_q <= mask_d;
      index_q <= index_d;
      force_q <= force_d;
      rdone_q <= rdone_d;
      wdone_q <= wdone_d;
      rtype_q <= rtype_d;
      state_q <= state_d;
      xport_q <= xport_d;
      step_q <= step_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs registered so the filter path sees a clean level.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      force_o_q <= '0;
      miss_o_q <= '0;
      l2_q <= '0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        force_o_q[p] <= force_q[p]; // see R1, R2
        miss_o_q[p] <= force_q[p]; // see R1, R2
        l2_q[p] <= hold_q[p][OFS_MODE[3:0]][MODE_LSB+1:MODE_LSB] == MODE_LAYER2; // see R16
      end
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_single_entry_filter = force_o_q;
  assign o_match_is_miss = miss_o_q;
  assign o_layer2_layout = l2_q;

  chk_rd_done: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R18
    (state_q == ACLTIA_READ && step_q == 4'h0) |-> ##13 (state_q == ACLTIA_READ) ##1 rdone_q[xport_q])
    else $error("read did not complete in fourteen cycles");
  chk_wr_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R18
    (state_q == ACLTIA_WRITE) |-> !wdone_q[xport_q])
    else $error("write flag set during write");
  chk_rd_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R18
    (state_q == ACLTIA_READ) |-> !rdone_q[xport_q])
    else $error("read flag set during read");
  chk_reset_flags: assert property (@(posedge i_clk) // see R17
    $fell(i_sys_rst) |-> (&rdone_q && &wdone_q))
    else $error("flags not one after reset");
  chk_offset_step: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R12
    (data_rd && !(i_reg_wr && i_reg_addr == ADDR_OFFSET)) |=> ofs_q == 8'($past(ofs_q) + 8'h01))
    else $error("offset did not advance");
  chk_hold_write: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R14
    (data_wr && ofs_q <= OFS_ENTRY_LAST) |=> hold_q[$past(cur_port)][$past(ofs_q[3:0])] ==
    $past(i_reg_wdata))
    else $error("holding buffer not written");
  chk_idle_table: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R15
    (state_q == ACLTIA_IDLE) |=> $stable(index_q[xport_q]) || $past(data_wr))
    else $error("entry index changed");
  chk_miss_out: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R1
    ##1 o_match_is_miss == $past(force_q))
    else $error("miss output mismatch");
  // Refused data accesses must leave the offset alone, or a later burst would drift.
  chk_refused_access: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R3, R5
    (i_reg_addr == ADDR_DATA && (i_reg_wr || i_reg_rd) && !data_wr && !data_rd)
    |=> ofs_q == $past(ofs_q))
    else $error("refused access moved the offset");
  chk_wr_done: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R18
    (state_q == ACLTIA_WRITE && step_q == 4'h0)
    |-> ##13 (state_q == ACLTIA_WRITE) ##1 wdone_q[xport_q])
    else $error("write did not complete in fourteen cycles");
  chk_busy_request: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R18
    (data_wr && ofs_q == OFS_ACCESS && state_q != ACLTIA_IDLE)
    |=> index_q[$past(cur_port)] == $past(index_q[cur_port]))
    else $error("request taken while a transfer runs");
  chk_table_write: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R15
    (state_q == ACLTIA_WRITE && lane_en)
    |=> table_mem[$past(xport_q)][$past(index_q[xport_q])][$past(step_q)] ==
    $past(hold_q[xport_q][step_q]))
    else $error("enabled byte not copied to the table");
  chk_table_skip: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R8
    (state_q == ACLTIA_WRITE && !lane_en)
    |=> table_mem[$past(xport_q)][$past(index_q[xport_q])][$past(step_q)] ==
    $past(table_mem[xport_q][index_q[xport_q]][step_q]))
    else $error("disabled byte changed in the table");
  chk_read_load: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R11
    (state_q == ACLTIA_READ && lane_en && !data_wr)
    |=> hold_q[$past(xport_q)][$past(step_q)] ==
    $past(table_mem[xport_q][index_q[xport_q]][step_q]))
    else $error("enabled byte not fetched into the holding buffer");
  chk_mask_high: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R6, R7
    (data_wr && ofs_q == OFS_MASK_HI)
    |=> mask_q[$past(cur_port)][13:8] == $past(i_reg_wdata[5:0]))
    else $error("upper mask byte not loaded");
  chk_mask_low: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see R6, R7
    (data_wr && ofs_q == OFS_MASK_LO)
    |=> mask_q[$past(cur_port)][7:0] == $past(i_reg_wdata))
    else $error("lower mask byte not loaded");
  cov_read: cover property (@(posedge i_clk) state_q == ACLTIA_READ ##14 rdone_q[xport_q]);
  cov_write: cover property (@(posedge i_clk) state_q == ACLTIA_WRITE ##14 wdone_q[xport_q]);
  cov_burst: cover property (@(posedge i_clk) data_rd ##1 data_rd ##1 data_rd);
  cov_refused: cover property (@(posedge i_clk) i_reg_addr == ADDR_DATA && i_reg_wr && !data_wr);
  cov_skip: cover property (@(posedge i_clk) state_q == ACLTIA_WRITE && !lane_en);
endmodule
`default_nettype wire

/* File: src/acltia_pkg.sv */
// Purpose: Constants for the rule table indirect access engine.
// Assumes: Byte wide register port, 40 MHz core clock.
// Notes: Offsets are the values written to the offset register, not addresses on the register port.
package acltia_pkg;
  localparam logic [7:0] ADDR_SELECT = 8'h6E;
  localparam logic [7:0] ADDR_OFFSET = 8'h6F;
  localparam logic [7:0] ADDR_DATA = 8'hA0;
  localparam logic [2:0] TABLE_RULE = 3'h2;
  localparam int SEL_TABLE_LSB = 5;
  localparam int SEL_DIR_BIT = 4;
  localparam logic [7:0] OFS_ENTRY_LAST = 8'h0D;
  localparam logic [7:0] OFS_MASK_HI = 8'h10;
  localparam logic [7:0] OFS_MASK_LO = 8'h11;
  localparam logic [7:0] OFS_ACCESS = 8'h12;
  localparam logic [7:0] OFS_FILTER = 8'h13;
  localparam int ENTRY_BYTES = 14;
  localparam int ENTRIES = 16;
  localparam int PORTS = 5;
  localparam int CTL_WDONE_BIT = 6;
  localparam int CTL_RDONE_BIT = 5;
  localparam int CTL_REQ_BIT = 4;
  localparam logic [7:0] FILTER_RESET = 8'h00;
  localparam logic [1:0] MODE_LAYER2 = 2'h1;
  localparam logic [7:0] OFS_MODE = 8'h01;
  localparam int MODE_LSB = 4;
  localparam int XFER_CYCLES = ENTRY_BYTES;
  typedef enum logic [1:0] {ACLTIA_IDLE, ACLTIA_READ, ACLTIA_WRITE} acltia_state_type;
endpackage

/* File: src/acltia_byte_lane.sv */
// Purpose: Byte enable decode for one entry byte.
// Assumes: Mask bit 13 minus k enables byte k.
// Notes: Purely combinational.
`timescale 1ns/100ps
`default_nettype none
module acltia_byte_lane
  import acltia_pkg::*;
(
  input wire logic [13:0] i_mask,
  input wire logic [3:0] i_index,
  output logic o_enable
);
  always_comb begin
    o_enable = 1'b0;
    if (i_index < 4'hE) begin
      o_enable = i_mask[4'hD - i_index]; // see R8
    end
  end
endmodule
`default_nettype wire

/* File: testbench/test_acl_table_indirect_access.sv */
// Purpose: Self-checking bench for the rule table indirect access engine.
// Assumes: Byte register port, strobes one cycle wide, read data one cycle after the strobe.
// Notes: Port 5 carries the table traffic and port 2 the filter bit.
`timescale 1ns/100ps
`default_nettype none
module test_acl_table_indirect_access;
  import acltia_pkg::*;
  logic i_clk, i_sys_rst, i_reg_wr, i_reg_rd;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, rv;
  logic [PORTS-1:0] o_single_entry_filter, o_match_is_miss, o_layer2_layout;
  int bad_count = 0;
  int n_checks = 0;

  acltia_top DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_single_entry_filter(o_single_entry_filter),
    .o_match_is_miss(o_match_is_miss), .o_layer2_layout(o_layer2_layout));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1;
    d = o_reg_rdata;
  endtask

  task automatic ind_wr(input logic [7:0] s, input logic [7:0] o, input logic [7:0] d);
    wr(ADDR_SELECT, s);
    wr(ADDR_OFFSET, o);
    wr(ADDR_DATA, d);
  endtask

  task automatic ind_rd(input logic [7:0] s, input logic [7:0] o, output logic [7:0] d);
    wr(ADDR_SELECT, s);
    wr(ADDR_OFFSET, o);
    rd(ADDR_DATA, d);
  endtask

  // Each status read rewrites the offset, because every accepted data access steps it.
  task automatic poll(input int b);
    int i;
    logic [7:0] d;
    for (i = 0; i < 40; i++) begin
      ind_rd(8'h55, OFS_ACCESS, d);
      if (d[b] === 1'b1) break;
    end
    if (i == 40) begin
      bad_count++;
      $display("[FAIL] %0t completion flag never set", $time);
      print_verdict();
    end
  endtask

  task automatic put_entry(input logic [7:0] base, input logic [7:0] mhi, input logic [7:0] mlo);
    poll(CTL_WDONE_BIT);
    wr(ADDR_SELECT, 8'h45);
    wr(ADDR_OFFSET, 8'h00);
    for (int k = 0; k < ENTRY_BYTES; k++) wr(ADDR_DATA, base + 8'(k));
    ind_wr(8'h45, OFS_MASK_HI, mhi);
    wr(ADDR_DATA, mlo);
    ind_wr(8'h45, OFS_ACCESS, 8'h1F);
    // A second request while the copy runs must be dropped.
    wr(ADDR_OFFSET, OFS_ACCESS);
    wr(ADDR_DATA, 8'h03);
    ind_rd(8'h55, OFS_ACCESS, rv);
    check(rv & 8'h40, 8'h00, "write flag not cleared");
    poll(CTL_WDONE_BIT);
    ind_rd(8'h55, OFS_ACCESS, rv);
    check(rv, 8'h7F, "status after write");
  endtask

  task automatic test_reset();
    ind_rd(8'h51, OFS_ACCESS, rv);
    check(rv, 8'h60, "status after reset");
    ind_rd(8'h51, OFS_FILTER, rv);
    check(rv, FILTER_RESET, "filter after reset");
  endtask

  task automatic test_filter();
    ind_wr(8'h42, OFS_FILTER, 8'hFF);
    ind_rd(8'h52, OFS_FILTER, rv);
    check(rv, 8'h01, "filter readback");
    check({3'h0, o_single_entry_filter}, 8'h02, "single entry set");
    check({3'h0, o_match_is_miss}, 8'h02, "miss set");
    ind_wr(8'h42, OFS_FILTER, 8'h00);
    repeat (3) @(posedge i_clk);
    #1;
    check({3'h0, o_single_entry_filter}, 8'h00, "single entry clear");
    check({3'h0, o_match_is_miss}, 8'h00, "hit mode");
  endtask

  task automatic test_entry();
    put_entry(8'hA0, 8'h3F, 8'hFF);
    put_entry(8'h10, 8'h15, 8'h55);
    ind_rd(8'h55, OFS_MASK_HI, rv);
    check(rv, 8'h15, "mask high");
    rd(ADDR_DATA, rv);
    check(rv, 8'h55, "mask low");
    // Holding bytes overwritten without a request must not reach the table.
    wr(ADDR_SELECT, 8'h45);
    wr(ADDR_OFFSET, 8'h00);
    for (int k = 0; k < ENTRY_BYTES; k++) wr(ADDR_DATA, 8'hEE);
    ind_wr(8'h45, OFS_MASK_HI, 8'h3F);
    wr(ADDR_DATA, 8'hFF);
    check({3'h0, o_layer2_layout}, 8'h00, "layout with hold EE");
    ind_wr(8'h45, OFS_ACCESS, 8'h0F);
    poll(CTL_RDONE_BIT);
    ind_rd(8'h55, OFS_ACCESS, rv);
    check(rv, 8'h6F, "status after read");
    wr(ADDR_SELECT, 8'h55);
    wr(ADDR_OFFSET, 8'h00);
    for (int k = 0; k < ENTRY_BYTES; k++) begin
      rd(ADDR_DATA, rv);
      check(rv, ((k % 2) == 1 ? 8'h10 : 8'hA0) + 8'(k), "entry byte");
    end
    check({3'h0, o_layer2_layout}, 8'h10, "layer 2 layout");
  endtask

  // Data writes with a foreign table code or the read direction must be ignored.
  task automatic test_refuse();
    ind_wr(8'h25, OFS_MASK_HI, 8'h00);
    ind_wr(8'h55, OFS_MASK_HI, 8'h00);
    ind_rd(8'h55, OFS_MASK_HI, rv);
    check(rv, 8'h3F, "mask after refused writes");
    rd(ADDR_OFFSET, rv);
    check(rv, 8'h11, "offset after one read step");
  endtask

  initial begin
    i_sys_rst = 1'b1;
    i_reg_addr = 8'h00;
    i_reg_wdata = 8'h00;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    test_reset();
    test_filter();
    test_entry();
    test_refuse();
    print_verdict();
  end
endmodule
`default_nettype wire
